// [rtl/rcfs_status_bank.sv]
// What this block does
// (RQ1) Frequency flag set when receive frequency is above 12, below 15 MHz.
// (RQ2) From 9-12 MHz or 15-19 MHz the frequency flag may read either level.
// (RQ3) Checksum-zero flag: result zero; low while computing, one on success.
// (RQ4) Checksum-zero undefined in frames; software uses checksum fail flag.
// (RQ5) Checksum-done sets when calculation ends; valid for compute command.
// (RQ6) Pending flag is OR of requesting sources whose enable bits are set.
// (RQ7) Timer-active high while the timer runs and will decrement next tick.
// (RQ8) Gated mode: timer-active follows register enable only, not the gate.
// (RQ9) Field-present follows current field detection without latching.
// (RQ10) Near-full high exactly when 64 minus fill count is at most threshold.
// (RQ11) Near-empty high exactly when fill count is at most threshold.
// (RQ12) Status at index 07h, read-only, reset pattern X100X01X.
// (RQ13) Writes to status address change no flag; bits derive from sources.
//
// The Avalon-MM register port is this design's own decision.
`include "rcfs_cfg.svh"
`default_nettype none

module rcfs_status_bank
	import rcfs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Pins
	input wire logic rx_field_i,
	input wire logic field_detect_i,
	// Source units, same clock
	input wire rcfs_crc_s crc_i,
	input wire rcfs_tmr_s tmr_i,
	input wire rcfs_irq_src_s irq_src_i,
	input wire logic [6:0] fifo_fill_count_i,
	// Status, threshold and interrupt
	output rcfs_status_s status_o,
	output logic [`RCFS_THR_W-1:0] fifo_threshold_o,
	output logic irq_o
);

	localparam int WIN_CYC = `RCFS_FREQ_WIN_NS * `RCFS_CLK_MHZ / 1000;
	localparam int LO_EDGES = `RCFS_FREQ_LO_MHZ * `RCFS_FREQ_WIN_NS / 1000;
	localparam int HI_EDGES = `RCFS_FREQ_HI_MHZ * `RCFS_FREQ_WIN_NS / 1000;
	localparam logic [9:0] WIN_LAST = 10'(WIN_CYC - 1);
	localparam logic [7:0] LO_CNT = 8'(LO_EDGES);
	localparam logic [7:0] HI_CNT = 8'(HI_EDGES);

	localparam rcfs_state_s ST_RST = '{
		bus: RCFS_BUS_IDLE,
		waitreq: 1'b1,
		rdata: 32'h0,
		rx_sync: 3'h0,
		fld_sync: 2'h0,
		win_cnt: 10'h0,
		edge_cnt: 8'h0,
		sts: `RCFS_STATUS_RST,
		thr: `RCFS_THR_RST,
		int_sts: 5'h0,
		int_en: 5'h0,
		irq: 1'b0
	};

	rcfs_state_s st;
	rcfs_state_s st_nxt;
	logic rx_edge;
	logic [7:0] edge_inc;
	logic [5:0] idx;
	logic wr_take;
	logic [4:0] ev;
	logic [4:0] clr;
	logic [31:0] rd_val;
	logic [6:0] room;

	assign idx = avs_address_i[7:2];

	always_comb
	begin
		st_nxt = st;
		ev = 5'h0;
		clr = 5'h0;
		rd_val = 32'h0;
		wr_take = 1'b0;

		// Pins pass two flops; the third stage only feeds edge detect
		st_nxt.rx_sync = {st.rx_sync[1:0], rx_field_i};
		st_nxt.fld_sync = {st.fld_sync[0], field_detect_i};
		rx_edge = st.rx_sync[1] & ~st.rx_sync[2];

		// Saturate so very high frequencies never wrap into range
		if (rx_edge && st.edge_cnt != 8'hFF)
			edge_inc = st.edge_cnt + 8'h01;
		else
			edge_inc = st.edge_cnt;

		// Edge count over a fixed window; quantisation of one edge
		// blurs the 125 kHz just above 12 MHz and just below 15 MHz
		if (st.win_cnt == WIN_LAST)
		begin
			st_nxt.win_cnt = 10'h0;
			st_nxt.edge_cnt = 8'h0;
			st_nxt.sts.freq_ok = (edge_inc > LO_CNT) && (edge_inc < HI_CNT); // RQ1 RQ2
		end
		else
		begin
			st_nxt.win_cnt = st.win_cnt + 10'h001;
			st_nxt.edge_cnt = edge_inc;
		end

		// Value in frames is whatever the engine reports
		st_nxt.sts.crc_zero = crc_i.busy ? 1'b0 : crc_i.result_zero; // RQ3 RQ4

		// Finish wins over a new start in the same cycle
		if (crc_i.done)
			st_nxt.sts.crc_done = 1'b1; // RQ5
		else if (crc_i.start)
			st_nxt.sts.crc_done = 1'b0;

		st_nxt.sts.irq_pend = |(irq_src_i.comm_req & irq_src_i.comm_en)
			| |(irq_src_i.misc_req & irq_src_i.misc_en); // RQ6

		if (tmr_i.gated_mode)
			st_nxt.sts.tmr_act = tmr_i.en_bits; // RQ8
		else
			st_nxt.sts.tmr_act = tmr_i.running; // RQ7

		st_nxt.sts.fld = st.fld_sync[1]; // RQ9

		room = 7'(`RCFS_FIFO_DEPTH - fifo_fill_count_i);
		st_nxt.sts.hi = room <= {1'b0, st.thr}; // RQ10
		st_nxt.sts.lo = fifo_fill_count_i <= {1'b0, st.thr}; // RQ11

		// Rising edges of the checksum-done, field, near-full and near-empty flags, and the falling edge of the field flag, raise sticky events
		ev[`RCFS_EV_CRC_DONE] = st_nxt.sts.crc_done & ~st.sts.crc_done;
		ev[`RCFS_EV_FIELD_ON] = st_nxt.sts.fld & ~st.sts.fld;
		ev[`RCFS_EV_FIELD_OFF] = ~st_nxt.sts.fld & st.sts.fld;
		ev[`RCFS_EV_NEAR_FULL] = st_nxt.sts.hi & ~st.sts.hi;
		ev[`RCFS_EV_NEAR_EMPTY] = st_nxt.sts.lo & ~st.sts.lo;

		case (idx)
			`RCFS_IDX_STATUS: rd_val = {24'h0, st.sts}; // RQ12
			`RCFS_IDX_CTRL: rd_val = {26'h0, st.thr};
			`RCFS_IDX_INT_STS: rd_val = {27'h0, st.int_sts};
			`RCFS_IDX_INT_EN: rd_val = {27'h0, st.int_en};
			default: rd_val = 32'h0;
		endcase

		// One wait cycle: data latched on take, write on the ack edge
		case (st.bus)
			RCFS_BUS_IDLE:
			begin
				if (avs_read_i || avs_write_i)
				begin
					st_nxt.bus = RCFS_BUS_ACK;
					st_nxt.waitreq = 1'b0;
					st_nxt.rdata = avs_read_i ? rd_val : 32'h0;
				end
			end
			RCFS_BUS_ACK:
			begin
				st_nxt.bus = RCFS_BUS_IDLE;
				st_nxt.waitreq = 1'b1;
				wr_take = avs_write_i & avs_byteenable_i[0];
			end
			default:
			begin
				st_nxt.bus = RCFS_BUS_IDLE;
				st_nxt.waitreq = 1'b1;
			end
		endcase

		// Status index has no write path at all
		if (wr_take)
		begin
			case (idx)
				`RCFS_IDX_CTRL:
					st_nxt.thr = avs_writedata_i[`RCFS_THR_W-1:0];
				`RCFS_IDX_INT_CLR: clr = avs_writedata_i[4:0];
				`RCFS_IDX_INT_EN: st_nxt.int_en = avs_writedata_i[4:0];
				default: st_nxt.thr = st.thr; // RQ13
			endcase
		end

		// Set wins over clear
		st_nxt.int_sts = (st.int_sts & ~clr) | ev;
		st_nxt.irq = |(st_nxt.int_sts & st_nxt.int_en);
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			st <= ST_RST;
		else
			st <= st_nxt;
	end

	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = st.waitreq;
	assign status_o = st.sts;
	assign fifo_threshold_o = st.thr;
	assign irq_o = st.irq;

	a_freq_in_band: assert property ( // RQ1
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.win_cnt == WIN_LAST && edge_inc > LO_CNT && edge_inc < HI_CNT)
		|=> st.sts.freq_ok)
		else $error("frequency flag low for in-band count");

	a_freq_out_band: assert property ( // RQ1
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.win_cnt == WIN_LAST && edge_inc <= LO_CNT)
		|=> !st.sts.freq_ok)
		else $error("frequency flag high for low count");

	a_crc_busy_zero: assert property ( // RQ3
		@(posedge core_clk_i) disable iff (!rst_b_i)
		crc_i.busy |=> !st.sts.crc_zero)
		else $error("checksum zero flag high while busy");

	a_crc_done_set: assert property ( // RQ5
		@(posedge core_clk_i) disable iff (!rst_b_i)
		crc_i.done ##1 !crc_i.start[*2] |=> st.sts.crc_done)
		else $error("checksum done flag not held");

	a_irq_pend_or: assert property ( // RQ6
		@(posedge core_clk_i) disable iff (!rst_b_i)
		rst_b_i |=> st.sts.irq_pend == $past(|(irq_src_i.comm_req
			& irq_src_i.comm_en) | |(irq_src_i.misc_req
			& irq_src_i.misc_en)))
		else $error("interrupt pending flag mismatch");

	a_timer_gated: assert property ( // RQ8
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(tmr_i.gated_mode && tmr_i.en_bits && !tmr_i.running)
		|=> st.sts.tmr_act)
		else $error("timer flag follows gate in gated mode");

	a_field_follow: assert property ( // RQ9
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!field_detect_i)[*3] |=> !st.sts.fld)
		else $error("field flag latched after field loss");

	a_near_full: assert property ( // RQ10
		@(posedge core_clk_i) disable iff (!rst_b_i)
		rst_b_i
		|=> st.sts.hi == $past(7'(`RCFS_FIFO_DEPTH - fifo_fill_count_i)
			<= {1'b0, st.thr}))
		else $error("near full flag mismatch");

	a_near_empty: assert property ( // RQ11
		@(posedge core_clk_i) disable iff (!rst_b_i)
		rst_b_i |=> st.sts.lo == $past(fifo_fill_count_i <= {1'b0, st.thr}))
		else $error("near empty flag mismatch");

	a_status_read: assert property ( // RQ12
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.bus == RCFS_BUS_IDLE && avs_read_i
			&& idx == `RCFS_IDX_STATUS)
		|=> !avs_waitrequest_o && avs_readdata_o == {24'h0, $past(st.sts)})
		else $error("status read returned wrong value");

	a_wait_one: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.bus == RCFS_BUS_IDLE && (avs_read_i || avs_write_i))
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle");

	a_thr_unchanged: assert property ( // RQ13
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(wr_take && idx == `RCFS_IDX_STATUS) |=> $stable(st.thr)
			&& $stable(st.int_en))
		else $error("status write changed state");

	a_freq_high_band: assert property ( // RQ1
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.win_cnt == WIN_LAST && edge_inc >= HI_CNT)
		|=> !st.sts.freq_ok)
		else $error("frequency flag high for high count");

	a_freq_hold: assert property ( // RQ1
		@(posedge core_clk_i) disable iff (!rst_b_i)
		st.win_cnt != WIN_LAST |=> $stable(st.sts.freq_ok))
		else $error("frequency flag moved inside a window");

	a_crc_zero_idle: assert property ( // RQ3
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(rst_b_i && !crc_i.busy)
		|=> st.sts.crc_zero == $past(crc_i.result_zero))
		else $error("checksum zero flag not following result");

	a_crc_start_clear: assert property ( // RQ5
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(crc_i.start && !crc_i.done) |=> !st.sts.crc_done)
		else $error("checksum done flag survived a new start");

	a_timer_free: assert property ( // RQ7
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(rst_b_i && !tmr_i.gated_mode)
		|=> st.sts.tmr_act == $past(tmr_i.running))
		else $error("timer flag not following running state");

	a_field_rise: assert property ( // RQ9
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(field_detect_i)[*3] |=> st.sts.fld)
		else $error("field flag low with field present");

	a_field_on_event: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!st.sts.fld && st.fld_sync[1])
		|=> st.int_sts[`RCFS_EV_FIELD_ON])
		else $error("field on event not recorded");

	a_event_clear: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(wr_take && idx == `RCFS_IDX_INT_CLR
			&& avs_writedata_i[`RCFS_EV_FIELD_ON] && !ev[`RCFS_EV_FIELD_ON])
		|=> !st.int_sts[`RCFS_EV_FIELD_ON])
		else $error("event bit not cleared");

	a_event_sticky: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!(wr_take && idx == `RCFS_IDX_INT_CLR)
		|=> (st.int_sts & $past(st.int_sts)) == $past(st.int_sts))
		else $error("event bit dropped without a clear");

	a_irq_held: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		((st.int_sts & st.int_en) != 5'h0 && !wr_take) |=> irq_o)
		else $error("interrupt dropped with enabled event set");

	a_ctrl_read: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.bus == RCFS_BUS_IDLE && avs_read_i && idx == `RCFS_IDX_CTRL)
		|=> avs_readdata_o == {26'h0, $past(st.thr)})
		else $error("threshold read returned wrong value");

	a_clear_read_zero: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.bus == RCFS_BUS_IDLE && avs_read_i && idx == `RCFS_IDX_INT_CLR)
		|=> avs_readdata_o == 32'h0)
		else $error("clear register read not zero");

	a_idle_waits: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st.bus == RCFS_BUS_IDLE && !avs_read_i && !avs_write_i)
		|=> avs_waitrequest_o)
		else $error("answer without a request");

endmodule

`default_nettype wire

// [rtl/rcfs_cfg.svh]
`ifndef RCFS_CFG_SVH
`define RCFS_CFG_SVH

// Register indices; byte address is four times the index
`define RCFS_IDX_STATUS 6'h07
`define RCFS_IDX_CTRL 6'h10
`define RCFS_IDX_INT_STS 6'h11
`define RCFS_IDX_INT_CLR 6'h12
`define RCFS_IDX_INT_EN 6'h13

// Status register reset value, undetermined bits taken as zero
`define RCFS_STATUS_RST 8'h42
`define RCFS_THR_RST 6'h08
`define RCFS_THR_W 6
`define RCFS_FIFO_DEPTH 7'h40

// Event bits of the interrupt status, clear and enable registers
`define RCFS_NUM_EV 5
`define RCFS_EV_CRC_DONE 0
`define RCFS_EV_FIELD_ON 1
`define RCFS_EV_FIELD_OFF 2
`define RCFS_EV_NEAR_FULL 3
`define RCFS_EV_NEAR_EMPTY 4

// Frequency measurement
`define RCFS_CLK_MHZ 125
`define RCFS_FREQ_WIN_NS 8000
`define RCFS_FREQ_LO_MHZ 12
`define RCFS_FREQ_HI_MHZ 15

`endif

// [rtl/rcfs_pkg.sv]
`default_nettype none

package rcfs_pkg;

	// Bit 7 down to bit 0 of the status register
	typedef struct packed {
		logic freq_ok;
		logic crc_zero;
		logic crc_done;
		logic irq_pend;
		logic tmr_act;
		logic fld;
		logic hi;
		logic lo;
	} rcfs_status_s;

	typedef struct packed {
		logic start;
		logic busy;
		logic result_zero;
		logic done;
	} rcfs_crc_s;

	typedef struct packed {
		logic running;
		logic gated_mode;
		logic en_bits;
	} rcfs_tmr_s;

	typedef struct packed {
		logic [7:0] comm_req;
		logic [7:0] comm_en;
		logic [7:0] misc_req;
		logic [7:0] misc_en;
	} rcfs_irq_src_s;

	typedef enum logic {
		RCFS_BUS_IDLE,
		RCFS_BUS_ACK
	} rcfs_bus_e;

	typedef struct packed {
		rcfs_bus_e bus;
		logic waitreq;
		logic [31:0] rdata;
		logic [2:0] rx_sync;
		logic [1:0] fld_sync;
		logic [9:0] win_cnt;
		logic [7:0] edge_cnt;
		rcfs_status_s sts;
		logic [5:0] thr;
		logic [4:0] int_sts;
		logic [4:0] int_en;
		logic irq;
	} rcfs_state_s;

endpackage

`default_nettype wire

// [dv/rcfs_status_bank_tb.sv]
`include "rcfs_cfg.svh"
`default_nettype none

`define CHK(n, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("unexpected %s exp %h got %h", n, e, g); \
		end \
	end

module rcfs_status_bank_tb
	import rcfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] rdat;
	logic wait_r;
	logic rx = 1'b0;
	logic fdet = 1'b0;
	rcfs_crc_s crc = '0;
	rcfs_tmr_s tmr = '0;
	rcfs_irq_src_s irq = '0;
	logic [6:0] fill = 7'h00;
	rcfs_status_s sts;
	logic [5:0] thr_o;
	logic irq_o;
	logic [5:0] thr = 6'h08;
	logic [5:0] k;
	logic fr = 1'b0;
	logic dn = 1'b0;
	logic ren = 1'b0;
	logic [31:0] ex;
	logic [31:0] q[$];
	int err_count = 0;
	int tests_run = 0;
	int seed = 2;
	realtime half = 37.0;

	rcfs_status_bank rcfs_status_bank_i (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.avs_address_i(adr),
		.avs_read_i(rd_en),
		.avs_write_i(wr_en),
		.avs_writedata_i(wdat),
		.avs_byteenable_i(be),
		.avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_r),
		.rx_field_i(rx),
		.field_detect_i(fdet),
		.crc_i(crc),
		.tmr_i(tmr),
		.irq_src_i(irq),
		.fifo_fill_count_i(fill),
		.status_o(sts),
		.fifo_threshold_o(thr_o),
		.irq_o(irq_o)
	);

	always #4 core_clk_i = ~core_clk_i;

	// Carrier is asynchronous to the core clock on purpose
	initial
	forever
	begin
		#(half);
		if (ren)
			rx = ~rx;
	end

	always @(posedge core_clk_i)
		if (rd_en && wait_r === 1'b0)
		begin
			ex = q.pop_front();
			`CHK("readdata", ex, rdat)
		end

	function logic [31:0] st();
		st = {24'h0, fr, ~crc.busy & crc.result_zero, dn,
			|((irq.comm_req & irq.comm_en) | (irq.misc_req & irq.misc_en)),
			tmr.gated_mode ? tmr.en_bits : tmr.running, fdet,
			7'h40 - fill <= {1'b0, thr}, fill <= {1'b0, thr}};
	endfunction

	task step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	task wt();
		do @(posedge core_clk_i); while (wait_r !== 1'b0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge core_clk_i);
		adr <= a;
		wdat <= d;
		be <= b;
		wr_en <= 1'b1;
		wt();
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge core_clk_i);
		adr <= a;
		rd_en <= 1'b1;
		wt();
		rd_en <= 1'b0;
	endtask

	// Pulse order: start, busy, result zero, done
	task crcp(input logic [3:0] v);
		@(posedge core_clk_i);
		crc <= v;
		@(posedge core_clk_i);
		crc.start <= 1'b0;
		crc.done <= 1'b0;
		if (v[0])
			dn = 1'b1;
		else if (v[3])
			dn = 1'b0;
		step(2);
	endtask

	// Two windows so at least one is measured wholly at the new rate
	task fq(input realtime h, input logic e);
		half = h;
		ren = 1'b1;
		step(2050);
		fr = e;
		rd(8'h1C, st());
		ren = 1'b0;
	endtask

	task finish_test();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		err_count++;
		finish_test();
	end

	initial
	begin
		step(2);
		`CHK("status_rst", `RCFS_STATUS_RST, sts)
		`CHK("thr_rst", `RCFS_THR_RST, thr_o)
		rst_b_i <= 1'b1;
		rd(8'h1C, st());
		wr(8'h1C, 32'hFF, 4'hF);
		rd(8'h1C, st());
		rd(8'h00, 32'h0);
		rd(8'h48, 32'h0);
		rd(8'h40, 32'h8);
		for (int i = 0; i < 24; i++)
		begin
			@(posedge core_clk_i);
			irq <= $random(seed) & $random(seed) & $random(seed);
			tmr <= 3'($random(seed));
			k = 6'($random(seed));
			fill <= i[0] ? 7'(k) + 7'(i[1]) : 7'h40 - 7'(k) - 7'(i[1]);
			wr(8'h40, {26'h0, k}, i == 5 ? 4'h0 : 4'h1);
			if (i != 5)
				thr = k;
			rd(8'h1C, st());
			rd(8'h40, {26'h0, thr});
		end
		crcp(4'hC);
		rd(8'h1C, st());
		crcp(4'h3);
		rd(8'h1C, st());
		crcp(4'hE);
		rd(8'h1C, st());
		crcp(4'h9);
		rd(8'h1C, st());
		crcp(4'h1);
		rd(8'h1C, st());
		wr(8'h48, 32'h1F, 4'hF);
		rd(8'h44, 32'h0);
		@(posedge core_clk_i);
		fdet <= 1'b1;
		step(5);
		rd(8'h1C, st());
		rd(8'h44, 32'h2);
		`CHK("irq_masked", 1'b0, irq_o)
		wr(8'h4C, 32'h2, 4'hF);
		step(3);
		`CHK("irq_on", 1'b1, irq_o)
		@(posedge core_clk_i);
		fdet <= 1'b0;
		step(5);
		rd(8'h1C, st());
		rd(8'h44, 32'h6);
		wr(8'h44, 32'h0, 4'hF);
		wr(8'h48, 32'h2, 4'hF);
		rd(8'h44, 32'h4);
		rd(8'h4C, 32'h2);
		step(3);
		`CHK("irq_off", 1'b0, irq_o)
		fq(37.0, 1'b1);
		fq(25.0, 1'b0);
		fq(36.0, 1'b1);
		fq(62.5, 1'b0);
		finish_test();
	end
endmodule

`default_nettype wire
